// *** pkg/adsq_params.svh ***
// Offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH
`define ADSQ_OFF_CTRL1 12'h000
`define ADSQ_OFF_CTRL2 12'h004
`define ADSQ_OFF_STAT 12'h008
`define ADSQ_OFF_RESULT 12'h00C
`define ADSQ_OFF_SLOT 12'h00C
`define ADSQ_BIT_ON 15
`define ADSQ_BIT_IDLE_STOP 13
`define ADSQ_FORM_LSB 8
`define ADSQ_TRIG_LSB 5
`define ADSQ_BIT_CLRA 4
`define ADSQ_BIT_AUTO_SAMPLE 2
`define ADSQ_BIT_SAMPLE_ACTIVE 1
`define ADSQ_BIT_DONE 0
`define ADSQ_REF_LSB 13
`define ADSQ_BIT_OFFC 12
`define ADSQ_BIT_SCAN 10
`define ADSQ_BIT_FILL_HALF_STATUS 7
`define ADSQ_RATE_LSB 2
`define ADSQ_BIT_SPLIT 1
`define ADSQ_BIT_ALT 0
`define ADSQ_CTRL1_WMASK 32'h0000A7F6
`define ADSQ_CTRL2_WMASK 32'h0000F43F
`define ADSQ_RESET_WORD 32'h00000000
`define ADSQ_AUTO_CONV_CYCLES 8'h0F
`endif

// *** pkg/adsq_pkg.sv ***
// Types shared by the converter sequencer
`default_nettype none
package adsq_pkg;
   typedef enum logic [1:0] {ADSQ_IDLE, ADSQ_SAMPLE, ADSQ_CONVERT} adsq_state_t;
   typedef enum logic [1:0] {ADSQ_REF_RAILS, ADSQ_REF_EXT_HIGH, ADSQ_REF_EXT_LOW, ADSQ_REF_EXT_BOTH} adsq_ref_t;
endpackage : adsq_pkg
`default_nettype wire

// *** core/adsq_control.sv ***
// Sequencing and control logic of a 10-bit successive-approximation converter
//
// Summary of operation
// - Converter works only while the module enable bit is set.
// - With idle_stop set, operation halts while the device is idle.
// - Integer formats right-justify; code 101 sign-extends, 100 and 000 zero-fill.
// - Fractional formats left-justify at bit 15 or bit 31; signed keep sign top.
// - Trigger source chooses software, pin edge, timer, charge unit or auto counter.
// - stop_on_first_interrupt clears auto_sample at the first interrupt.
// - auto_sample restarts sampling after each conversion and sets sample_active.
// - Without auto_sample, software writes 1 to sample_active to start sampling.
// - Trigger code 000: software writing 0 to sample_active starts conversion.
// - Nonzero trigger: hardware clears sample_active at the trigger event.
// - Done bit is set when a conversion completes.
// - Software clears done by writing 0; conversions in progress are unaffected.
// - Done bit clears when a new conversion starts.
// - Reference field selects rails or external references; top bit set means rails.
// - Offset calibration ties both sampler inputs to the low reference.
// - input_scan set steps through the selected inputs; clear means no scanning.
// - fill_half_status shows upper half being filled in split-buffer mode.
// - Interrupt is raised after every interrupt_rate plus one sequences.
// - split_buffer selects two 8-word halves or one 16-word buffer.
// - alternate_sample uses A first then B, A, B; otherwise always A.
//
// Our own choices: the address map and the APB slave port.
`include "adsq_params.svh"
`default_nettype none
module adsq_control
   import adsq_pkg::*;
#(
   parameter int unsigned RES_W = 10,
   parameter int unsigned DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic device_idle,
   input wire logic external_interrupt_pin,
   input wire logic timer_period_match,
   input wire logic charge_time_unit_trigger,
   input wire logic core_done,
   input wire logic [RES_W-1:0] core_result,
   output logic core_sample,
   output logic core_start,
   output logic core_select_b,
   output logic core_scan,
   output logic core_offset_cal,
   output logic [1:0] core_reference,
   output logic [3:0] store_index,
   output logic store_valid,
   output logic [31:0] store_word,
   output logic conv_interrupt
);
   // ==========================================
   // Registers
   logic [31:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
   logic [31:0] result_mem [DEPTH];
   adsq_state_t state_q, state_d;
   logic [3:0] seq_cnt_q, wr_ptr_q;
   logic [7:0] auto_cnt_q;
   logic pin_q, alt_b_q, half_q;
   logic [31:0] prdata_q;
   logic [3:0] slot_q;

   // ==========================================
   // Decode
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire wr_c1 = wr && paddr == `ADSQ_OFF_CTRL1;
   wire wr_c2 = wr && paddr == `ADSQ_OFF_CTRL2;
   wire wr_slot = wr && paddr == `ADSQ_OFF_STAT;
   wire rd_res = access & ~pwrite && paddr[11:6] == 6'h01;
   wire mapped = paddr == `ADSQ_OFF_CTRL1 || paddr == `ADSQ_OFF_CTRL2 || paddr == `ADSQ_OFF_STAT
      || paddr[11:6] == 6'h01;
   wire module_on = ctrl1_q[`ADSQ_BIT_ON];
   wire run = module_on & ~(ctrl1_q[`ADSQ_BIT_IDLE_STOP] & device_idle);
   wire [2:0] form = ctrl1_q[`ADSQ_FORM_LSB +: 3];
   wire [2:0] trig = ctrl1_q[`ADSQ_TRIG_LSB +: 3];
   wire auto_sample = ctrl1_q[`ADSQ_BIT_AUTO_SAMPLE];
   wire sample_active = ctrl1_q[`ADSQ_BIT_SAMPLE_ACTIVE];
   wire [3:0] rate = ctrl2_q[`ADSQ_RATE_LSB +: 4];
   wire split = ctrl2_q[`ADSQ_BIT_SPLIT];
   wire [2:0] vcfg = ctrl2_q[`ADSQ_REF_LSB +: 3];
   wire pin_edge = external_interrupt_pin & ~pin_q;
   // Hardware trigger chosen by the source field; reserved codes never fire
   wire hw_trig = (trig == 3'h1 && pin_edge) || (trig == 3'h2 && timer_period_match)
      || (trig == 3'h3 && charge_time_unit_trigger)
      || (trig == 3'h7 && auto_cnt_q == `ADSQ_AUTO_CONV_CYCLES);
   wire sw_start = trig == 3'h0 && wr_c1 && !pwdata[`ADSQ_BIT_SAMPLE_ACTIVE] && sample_active;
   wire start_conv = run && state_q == ADSQ_SAMPLE && (sw_start || (trig != 3'h0 && hw_trig));
   wire conv_end = run && state_q == ADSQ_CONVERT && core_done;
   wire irq_now = conv_end && seq_cnt_q == rate;
   wire sw_sample_active_set = wr_c1 && pwdata[`ADSQ_BIT_SAMPLE_ACTIVE] && !auto_sample;

   // ==========================================
   // Result formatting
   function automatic logic [31:0] fmt(input logic [2:0] code, input logic [RES_W-1:0] r);
      logic [RES_W-1:0] s;
      s = {~r[RES_W-1], r[RES_W-2:0]};
      case (code)
         // 16-bit signed integer: sign fills only up to bit 15, upper half stays zero like the other 16-bit codes
         3'h1: fmt = {16'h0000, {(16-RES_W){s[RES_W-1]}}, s};
         3'h2: fmt = {16'h0000, r, 6'h00};
         3'h3: fmt = {16'h0000, s, 6'h00};
         3'h4: fmt = {22'h000000, r};
         3'h5: fmt = {{22{s[RES_W-1]}}, s};
         3'h6: fmt = {r, 22'h000000};
         3'h7: fmt = {s, 22'h000000};
         default: fmt = {22'h000000, r};
      endcase
   endfunction

   // ==========================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ADSQ_IDLE: if (run && (sw_sample_active_set || auto_sample)) state_d = ADSQ_SAMPLE;
         ADSQ_SAMPLE: if (!run) state_d = ADSQ_IDLE; else if (start_conv) state_d = ADSQ_CONVERT;
         ADSQ_CONVERT: if (!run) state_d = ADSQ_IDLE;
            else if (conv_end) state_d = (auto_sample && !(irq_now && ctrl1_q[`ADSQ_BIT_CLRA])) ? ADSQ_SAMPLE : ADSQ_IDLE;
         default: state_d = ADSQ_IDLE;
      endcase
   end

   always_comb begin
      ctrl1_d = ctrl1_q;
      if (wr_c1) begin
         ctrl1_d = (ctrl1_q & ~`ADSQ_CTRL1_WMASK) | (pwdata & `ADSQ_CTRL1_WMASK);
         ctrl1_d[`ADSQ_BIT_DONE] = ctrl1_q[`ADSQ_BIT_DONE] & pwdata[`ADSQ_BIT_DONE];
         if (auto_sample) ctrl1_d[`ADSQ_BIT_SAMPLE_ACTIVE] = sample_active;
         if (trig != 3'h0) ctrl1_d[`ADSQ_BIT_SAMPLE_ACTIVE] = sample_active | pwdata[`ADSQ_BIT_SAMPLE_ACTIVE];
      end
      if (start_conv) begin
         ctrl1_d[`ADSQ_BIT_SAMPLE_ACTIVE] = 1'b0;
         ctrl1_d[`ADSQ_BIT_DONE] = 1'b0;
      end
      if (state_d == ADSQ_SAMPLE) ctrl1_d[`ADSQ_BIT_SAMPLE_ACTIVE] = 1'b1;
      if (irq_now && ctrl1_q[`ADSQ_BIT_CLRA]) ctrl1_d[`ADSQ_BIT_AUTO_SAMPLE] = 1'b0;
      // Hardware set wins over a software clear in the same cycle
      if (conv_end) ctrl1_d[`ADSQ_BIT_DONE] = 1'b1;
      if (!module_on) ctrl1_d[`ADSQ_BIT_SAMPLE_ACTIVE] = 1'b0;
   end

   always_comb begin
      ctrl2_d = ctrl2_q;
      if (wr_c2) ctrl2_d = (ctrl2_q & ~`ADSQ_CTRL2_WMASK) | (pwdata & `ADSQ_CTRL2_WMASK);
      ctrl2_d[`ADSQ_BIT_FILL_HALF_STATUS] = split & half_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_q <= `ADSQ_RESET_WORD;
         ctrl2_q <= `ADSQ_RESET_WORD;
         state_q <= ADSQ_IDLE;
         pin_q <= 1'b0;
      end else begin
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         state_q <= state_d;
         pin_q <= external_interrupt_pin;
      end
   end

   // Internal counter measures the sampling time for the auto-convert source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) auto_cnt_q <= 8'h00;
      else if (state_q != ADSQ_SAMPLE) auto_cnt_q <= 8'h00;
      else if (auto_cnt_q != `ADSQ_AUTO_CONV_CYCLES) auto_cnt_q <= auto_cnt_q + 8'h01;
   end

   // ==========================================
   // Sequence counting, store pointer, halves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_cnt_q <= 4'h0;
         wr_ptr_q <= 4'h0;
         half_q <= 1'b0;
         alt_b_q <= 1'b0;
         conv_interrupt <= 1'b0;
      end else begin
         conv_interrupt <= irq_now;
         if (!module_on || wr_c2) begin
            seq_cnt_q <= 4'h0;
            wr_ptr_q <= 4'h0;
            half_q <= 1'b0;
            alt_b_q <= 1'b0;
         end else if (conv_end) begin
            alt_b_q <= ctrl2_q[`ADSQ_BIT_ALT] & ~alt_b_q;
            if (irq_now) begin
               seq_cnt_q <= 4'h0;
               // Split mode swaps halves; otherwise the next sequence overwrites from slot 0
               half_q <= split & ~half_q;
               wr_ptr_q <= (split && !half_q) ? 4'h8 : 4'h0;
            end else begin
               seq_cnt_q <= seq_cnt_q + 4'h1;
               wr_ptr_q <= wr_ptr_q + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (conv_end) result_mem[wr_ptr_q] <= fmt(form, core_result);
   end

   // ==========================================
   // Core outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_sample <= 1'b0;
         core_start <= 1'b0;
         core_select_b <= 1'b0;
         core_scan <= 1'b0;
         core_offset_cal <= 1'b0;
         core_reference <= 2'b00;
         store_index <= 4'h0;
         store_valid <= 1'b0;
         store_word <= 32'h00000000;
      end else begin
         core_sample <= state_d == ADSQ_SAMPLE;
         core_start <= start_conv;
         core_select_b <= alt_b_q;
         core_scan <= ctrl2_q[`ADSQ_BIT_SCAN];
         core_offset_cal <= ctrl2_q[`ADSQ_BIT_OFFC];
         core_reference <= vcfg[2] ? 2'b00 : vcfg[1:0];
         store_index <= wr_ptr_q;
         store_valid <= conv_end;
         store_word <= fmt(form, core_result);
      end
   end

   // ==========================================
   // APB read path; no wait state, the read word, result memory included, is registered in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         slot_q <= 4'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         if (wr_slot) slot_q <= pwdata[3:0];
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite) begin
            if (paddr == `ADSQ_OFF_CTRL1) prdata <= ctrl1_q;
            else if (paddr == `ADSQ_OFF_CTRL2) prdata <= ctrl2_q;
            else if (paddr == `ADSQ_OFF_STAT) prdata <= {26'h0000000, state_q, slot_q[1:0] & 2'b00, 2'b00};
            else if (paddr[11:6] == 6'h01) prdata <= result_mem[paddr[5:2]];
            else prdata <= 32'h00000000;
         end
         prdata_q <= rd_res ? prdata : prdata_q;
      end
   end
endmodule : adsq_control
`default_nettype wire

// *** tb/adsq_control_asserts.sv ***
// Port checker for the converter sequencer
`default_nettype none
module adsq_control_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic core_done,
   input wire logic core_sample,
   input wire logic core_start,
   input wire logic store_valid,
   input wire logic conv_interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========
   // Bus answer
   ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   ready_single_a: assert property (pready |=> !pready) else $error("pready too long");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad error data");
   // ==========
   // Sequencing
   start_pulse_a: assert property (core_start |=> !core_start) else $error("start too long");
   start_ends_sample_a: assert property (core_start |-> $past(core_sample)) else $error("start unsampled");
   store_after_done_a: assert property (store_valid |-> $past(core_done)) else $error("store no done");
   irq_with_store_a: assert property (conv_interrupt |-> store_valid) else $error("irq no store");
   cover property (conv_interrupt);
   cover property (pslverr);
   cover property (core_start);
endmodule // adsq_control_asserts
bind adsq_control adsq_control_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .core_done, .core_sample, .core_start, .store_valid, .conv_interrupt);
`default_nettype wire

// *** tb/adsq_core_model.sv ***
// Behavioural analog sampler and converter core
`default_nettype none
module adsq_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic core_start,
   input wire logic [9:0] res_in,
   input wire logic [3:0] lat,
   output logic core_done,
   output logic [9:0] core_result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt_q;
   // Latency varies so the sequencer meets quick and slow conversions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 5'h00;
         core_done <= 1'h0;
      end else begin
         core_done <= (cnt_q == 5'h01);
         if (core_start) cnt_q <= 5'(lat) + 5'h02;
         else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      end
   end
   // Outside the done pulse the lines show the inverse, never a stale copy
   assign core_result = core_done ? res_in : ~res_in;
endmodule // adsq_core_model
`default_nettype wire

// *** tb/test_adsq_control.sv ***
// Self-checking bench of the converter sequencer
`default_nettype none
module test_adsq_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, device_idle = 0, err;
   logic external_interrupt_pin = 0, timer_period_match = 0, charge_time_unit_trigger = 0;
   logic core_done, pready, pslverr, core_sample, core_start, core_select_b, core_scan, core_offset_cal;
   logic store_valid, conv_interrupt;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, store_word, q, w;
   logic [9:0] core_result, res_in = 10'h000;
   logic [3:0] store_index, lat = 4'h0;
   logic [1:0] core_reference;
   int n_fail = 0, num_checks = 0, cyc = 0, n, k;
   always #4 pclk = ~pclk;
   adsq_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .device_idle, .external_interrupt_pin, .timer_period_match, .charge_time_unit_trigger, .core_done,
      .core_result, .core_sample, .core_start, .core_select_b, .core_scan, .core_offset_cal, .core_reference,
      .store_index, .store_valid, .store_word, .conv_interrupt);
   adsq_core_model i_core (.pclk, .presetn, .core_start, .res_in, .lat, .core_done, .core_result);
   // ==========
   // Helpers
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [31:0] fmt(input logic [2:0] c, input logic [9:0] r);
      logic [9:0] s;
      s = r ^ 10'h200;
      case (c)
         3'h1: return {16'h0, {6{s[9]}}, s};
         3'h2: return {16'h0, r, 6'h00};
         3'h3: return {16'h0, s, 6'h00};
         3'h5: return {{22{s[9]}}, s};
         3'h6: return {r, 22'h0};
         3'h7: return {s, 22'h0};
         default: return {22'h0, r};
      endcase
   endfunction
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 40000) begin
         n_fail++;
         end_sim;
      end
   end
   // ==========
   // Tests
   initial begin
      n = $urandom(32'h76DC806E);
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(0, 12'h000, 0);
      chk("ctrl1", 0, q);
      apb(0, 12'h004, 0);
      chk("ctrl2", 0, q);
      apb(0, 12'h020, 0);
      chk("slverr", 1, err);
      $display("test reset done");
      for (int f = 0; f < 8; f++) begin
         res_in <= 10'($urandom);
         lat <= 4'($urandom_range(0, 9));
         apb(1, 12'h000, 32'h8000 | (32'(f) << 8));
         apb(1, 12'h000, 32'h8002 | (32'(f) << 8));
         @(negedge pclk);
         chk("sample", 1, core_sample);
         apb(1, 12'h000, 32'h8000 | (32'(f) << 8));
         k = 0;
         while (store_valid !== 1'h1 && k++ < 64) @(negedge pclk);
         chk("word", fmt(3'(f), res_in), store_word);
         apb(0, 12'h000, 0);
         chk("done", 1, q[0]);
         chk("sample_end", 0, q[1]);
      end
      apb(1, 12'h000, 32'h8001);
      apb(0, 12'h000, 0);
      chk("done_keep", 1, q[0]);
      apb(1, 12'h000, 32'h8000);
      apb(0, 12'h000, 0);
      chk("done_clr", 0, q[0]);
      $display("test formats done");
      for (int v = 0; v < 8; v++) begin
         w = (32'(v) << 13) | ($urandom & 32'h1400);
         apb(1, 12'h004, w);
         apb(0, 12'h004, 0);
         chk("ctrl2", w, q);
         chk("ref", v[2] ? 0 : v & 3, core_reference);
         chk("offset_calibration", w[12], core_offset_cal);
         chk("scan", w[10], core_scan);
      end
      $display("test ctrl2 done");
      n = $urandom_range(1, 3);
      apb(1, 12'h004, (32'(n) << 2) | 32'h2);
      apb(1, 12'h000, 32'h80F4);
      k = 0;
      w = 0;
      while (conv_interrupt !== 1'h1 && k++ < 2000) begin
         @(negedge pclk);
         if (store_valid === 1'h1) w++;
      end
      chk("rate", n + 1, w);
      repeat (8) @(posedge pclk);
      apb(0, 12'h000, 0);
      chk("auto_off", 0, q[2]);
      apb(0, 12'h004, 0);
      chk("half", 1, q[7]);
      $display("test auto done");
      apb(1, 12'h004, 32'h1);
      apb(1, 12'h000, 32'h8020);
      res_in <= 10'($urandom);
      apb(1, 12'h000, 32'h8022);
      @(negedge pclk);
      chk("sample_a", 1, core_sample);
      chk("select_a", 0, core_select_b);
      @(posedge pclk);
      external_interrupt_pin <= 1'h1;
      @(posedge pclk);
      external_interrupt_pin <= 1'h0;
      k = 0;
      while (store_valid !== 1'h1 && k++ < 64) @(negedge pclk);
      chk("pin_word", fmt(3'h0, res_in), store_word);
      chk("index", 0, store_index);
      @(negedge pclk);
      chk("select_b", 1, core_select_b);
      $display("test pin done");
      apb(1, 12'h000, 32'hA000);
      device_idle <= 1'h1;
      apb(1, 12'h000, 32'hA002);
      @(negedge pclk);
      chk("idle_stop", 0, core_sample);
      device_idle <= 1'h0;
      apb(1, 12'h000, 32'h0);
      @(negedge pclk);
      chk("off", 0, core_sample);
      $display("test idle done");
      end_sim;
   end
endmodule // test_adsq_control
`default_nettype wire
